// ===== verilog/tap_pkg.sv
// Shared constants and types of the SRAM boundary-scan test port.
// Assumes one test clock domain and one system clock domain.

package tap_pkg;

  // ****************************************
  // Register sizes
  // ****************************************
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 109;
  localparam int OE_CELL = 108;

  // ****************************************
  // Capture and reset values
  // ****************************************
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [BSR_LEN-1:0] BSR_RESET = {1'h1, {(BSR_LEN-1){1'h0}}};
  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

  // ****************************************
  // Default instruction codes and identity
  // ****************************************
  localparam logic [IR_W-1:0] CODE_EXTEST_DEF = 3'h0;
  localparam logic [IR_W-1:0] CODE_IDCODE_DEF = 3'h1;
  localparam logic [IR_W-1:0] CODE_SAMPLEZ_DEF = 3'h2;
  localparam logic [IR_W-1:0] CODE_SAMPLE_DEF = 3'h4;
  localparam logic [IR_W-1:0] CODE_BYPASS_DEF = 3'h7;
  // Arbitrary identity value, lowest bit set as a scan chain expects
  localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h0abc_d001;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_type;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_ID, SEL_BSR
  } sel_type;

  // Output control word handed from the test clock to the system clock
  typedef struct packed {
    logic extest;
    logic floating;
    logic drive_en;
  } ctl_type;

endpackage

// ===== verilog/level_sync.sv
// Two-stage synchroniser for independent level signals.
// Assumes each bit may change at any time relative to clk.

`timescale 1ns/1ns

module level_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // Both stages advance only while enabled
  always_comb begin
    meta_next = en ? d : meta_reg;
    q_next = en ? meta_reg : q;
  end

  // First stage is read by the second stage only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end

endmodule

// ===== verilog/sram_boundary_scan_tap.sv
// Boundary-scan test access port of a synchronous SRAM.
// Assumes tck is a slow test clock (period above three clk periods) and
// that the system pins and memory core sit in the clk domain.
//
// Contract
// - Inputs taken on tck rise, outputs on fall.
// - Mode select sampled on rise, floats high.
// - Serial input pulled up, feeds selected MSB.
// - Serial output is LSB, driven only shifting.
// - Five mode-high edges reset port, memory unaffected.
// - Power-up reset floats tdo, memory unaffected.
// - One register in path, chosen by instruction.
// - Three-bit instruction, identity-read after resets.
// - Instruction capture loads 01 into low bits.
// - One-bit bypass register, cleared on capture.
// - Boundary register captures ring, shifts in shift.
// - Extest, sample and float instructions capture ring.
// - Identity register loaded on capture, shifted out.
// - New instruction takes effect at instruction update.
// - Float instruction tristates read data until update.
// - Extest drives preloaded cells onto output pins.
// - Cell 108 enables read data, preset high.

`timescale 1ns/1ns

module sram_boundary_scan_tap #(
  parameter int IN_W = 64,
  parameter int OUT_W = 36,
  parameter int IN_BASE = 0,
  parameter int OUT_BASE = 64,
  parameter logic [tap_pkg::IR_W-1:0] CODE_EXTEST = tap_pkg::CODE_EXTEST_DEF,
  parameter logic [tap_pkg::IR_W-1:0] CODE_IDCODE = tap_pkg::CODE_IDCODE_DEF,
  parameter logic [tap_pkg::IR_W-1:0] CODE_SAMPLEZ = tap_pkg::CODE_SAMPLEZ_DEF,
  parameter logic [tap_pkg::IR_W-1:0] CODE_SAMPLE = tap_pkg::CODE_SAMPLE_DEF,
  parameter logic [tap_pkg::IR_W-1:0] CODE_BYPASS = tap_pkg::CODE_BYPASS_DEF,
  parameter logic [tap_pkg::ID_W-1:0] ID_VALUE = tap_pkg::ID_VALUE_DEF
) (
  // System clock domain
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  // Memory core and package pins
  input wire logic [IN_W-1:0] core_in,
  input wire logic [OUT_W-1:0] core_q,
  input wire logic core_q_oe,
  output logic [OUT_W-1:0] pin_q,
  output logic pin_q_oe
);

  // ****************************************
  // Parameter checks
  // ****************************************
  localparam int RING_W = IN_W + OUT_W + 1;

  // Cell order must fit below the output enable cell without overlap
  generate
    if (IN_W < 1 || OUT_W < 1 || OUT_BASE < IN_BASE + IN_W || OUT_BASE + OUT_W > tap_pkg::OE_CELL) begin : g_bad
      $error("Boundary cell layout does not fit");
    end
  endgenerate

  // ****************************************
  // Declarations
  // ****************************************
  logic rst_meta_reg;
  logic rst_tck_n_reg;
  tap_pkg::tap_state_type state_reg, state_next;
  logic [tap_pkg::IR_W-1:0] ir_reg, ir_next;
  logic [tap_pkg::IR_W-1:0] ir_sh_reg, ir_sh_next;
  logic bypass_reg, bypass_next;
  logic [tap_pkg::ID_W-1:0] id_sh_reg, id_sh_next;
  logic [tap_pkg::BSR_LEN-1:0] bsr_sh_reg, bsr_sh_next;
  logic [tap_pkg::BSR_LEN-1:0] upd_reg, upd_next;
  logic [tap_pkg::BSR_LEN-1:0] ring;
  logic [RING_W-1:0] ring_s;
  logic tdo_out_next, tdo_oe_next;
  tap_pkg::sel_type sel;
  tap_pkg::ctl_type xw_ctl_reg, xw_ctl_next;
  logic [OUT_W-1:0] xw_drive_reg, xw_drive_next;
  logic tgl_reg, tgl_next;
  logic [2:0] tms_cnt_reg, tms_cnt_next;
  logic tgl_s;
  logic tgl_seen_reg, tgl_seen_next;
  tap_pkg::ctl_type ctl_reg, ctl_next;
  logic [OUT_W-1:0] drive_reg, drive_next;
  logic [OUT_W-1:0] pin_q_next;
  logic pin_q_oe_next;

  // Register chosen by an instruction; reserved codes fall to bypass
  function automatic tap_pkg::sel_type sel_of(input logic [tap_pkg::IR_W-1:0] code);
    if (code == CODE_IDCODE) begin
      return tap_pkg::SEL_ID;
    end else if (code == CODE_EXTEST || code == CODE_SAMPLE || code == CODE_SAMPLEZ) begin
      return tap_pkg::SEL_BSR;
    end else begin
      return tap_pkg::SEL_BYPASS;
    end
  endfunction

  // ****************************************
  // Test clock reset
  // ****************************************
  // Asynchronous entry, release on the second tck rise
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'h0;
      rst_tck_n_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_tck_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // Controller
  // ****************************************
  // Next state from mode select sampled on the rising edge
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tap_pkg::TLR: state_next = tms ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: state_next = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: state_next = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: state_next = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR: state_next = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: state_next = tms ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: state_next = tms ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: state_next = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: state_next = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: state_next = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: state_next = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR: state_next = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: state_next = tms ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: state_next = tms ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: state_next = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: state_next = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
    endcase
  end

  // State register, mode select taken on the rising edge
  always_ff @(posedge tck or negedge rst_tck_n_reg) begin
    if (!rst_tck_n_reg) begin
      state_reg <= tap_pkg::TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Instruction register
  // ****************************************
  // Capture pattern, shift from the serial input, update on exit
  always_comb begin
    ir_next = ir_reg;
    ir_sh_next = ir_sh_reg;
    if (state_reg == tap_pkg::TLR) begin
      ir_next = CODE_IDCODE;
    end
    if (state_reg == tap_pkg::CAP_IR) begin
      ir_sh_next = {ir_reg[tap_pkg::IR_W-1:2], tap_pkg::IR_CAPTURE};
    end
    if (state_reg == tap_pkg::SH_IR) begin
      ir_sh_next = {tdi, ir_sh_reg[tap_pkg::IR_W-1:1]};
    end
    if (state_reg == tap_pkg::UPD_IR) begin
      ir_next = ir_sh_reg;
    end
  end

  // Instruction and its shift stage
  always_ff @(posedge tck or negedge rst_tck_n_reg) begin
    if (!rst_tck_n_reg) begin
      ir_reg <= CODE_IDCODE;
      ir_sh_reg <= CODE_IDCODE;
    end else begin
      ir_reg <= ir_next;
      ir_sh_reg <= ir_sh_next;
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  level_sync #(
    .W(RING_W)
  ) u_ring_sync (
    .clk(tck),
    .nrst(rst_tck_n_reg),
    .en(1'h1),
    .d({pin_q_oe, pin_q, core_in}),
    .q(ring_s)
  );

  // Pin ring in cell order, unbonded cells read zero
  always_comb begin
    ring = '0;
    ring[IN_BASE +: IN_W] = ring_s[IN_W-1:0];
    ring[OUT_BASE +: OUT_W] = ring_s[IN_W +: OUT_W];
    ring[tap_pkg::OE_CELL] = ring_s[RING_W-1];
  end

  assign sel = sel_of(ir_reg);

  // Capture, shift and update of the selected data register
  always_comb begin
    bypass_next = bypass_reg;
    id_sh_next = id_sh_reg;
    bsr_sh_next = bsr_sh_reg;
    upd_next = upd_reg;
    if (state_reg == tap_pkg::CAP_DR) begin
      unique case (sel)
        tap_pkg::SEL_BYPASS: bypass_next = 1'h0;
        tap_pkg::SEL_ID: id_sh_next = ID_VALUE;
        tap_pkg::SEL_BSR: bsr_sh_next = ring;
      endcase
    end
    if (state_reg == tap_pkg::SH_DR) begin
      unique case (sel)
        tap_pkg::SEL_BYPASS: bypass_next = tdi;
        tap_pkg::SEL_ID: id_sh_next = {tdi, id_sh_reg[tap_pkg::ID_W-1:1]};
        tap_pkg::SEL_BSR: bsr_sh_next = {tdi, bsr_sh_reg[tap_pkg::BSR_LEN-1:1]};
      endcase
    end
    if (state_reg == tap_pkg::UPD_DR && (ir_reg == CODE_EXTEST || ir_reg == CODE_SAMPLE)) begin
      upd_next = bsr_sh_reg;
    end
    if (state_reg == tap_pkg::TLR) begin
      upd_next = tap_pkg::BSR_RESET;
    end
  end

  // Data shift stages and the preload latch
  always_ff @(posedge tck or negedge rst_tck_n_reg) begin
    if (!rst_tck_n_reg) begin
      bypass_reg <= 1'h0;
      id_sh_reg <= '0;
      bsr_sh_reg <= '0;
      upd_reg <= tap_pkg::BSR_RESET;
    end else begin
      bypass_reg <= bypass_next;
      id_sh_reg <= id_sh_next;
      bsr_sh_reg <= bsr_sh_next;
      upd_reg <= upd_next;
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  // Lowest bit of the register in the path, enabled only when shifting
  always_comb begin
    tdo_out_next = 1'h0;
    tdo_oe_next = state_reg == tap_pkg::SH_IR || state_reg == tap_pkg::SH_DR;
    if (state_reg == tap_pkg::SH_IR) begin
      tdo_out_next = ir_sh_reg[0];
    end else if (state_reg == tap_pkg::SH_DR) begin
      unique case (sel)
        tap_pkg::SEL_BYPASS: tdo_out_next = bypass_reg;
        tap_pkg::SEL_ID: tdo_out_next = id_sh_reg[0];
        tap_pkg::SEL_BSR: tdo_out_next = bsr_sh_reg[0];
      endcase
    end
  end

  // Output stage moves on the falling edge only
  always_ff @(negedge tck or negedge rst_tck_n_reg) begin
    if (!rst_tck_n_reg) begin
      tdo_out <= 1'h0;
      tdo_oe <= 1'h0;
    end else begin
      tdo_out <= tdo_out_next;
      tdo_oe <= tdo_oe_next;
    end
  end

  // ****************************************
  // Hand-off to the system clock
  // ****************************************
  // Word held stable, toggle marks each change of it
  always_comb begin
    xw_ctl_next.extest = ir_reg == CODE_EXTEST;
    xw_ctl_next.floating = ir_reg == CODE_SAMPLEZ;
    xw_ctl_next.drive_en = upd_reg[tap_pkg::OE_CELL];
    xw_drive_next = upd_reg[OUT_BASE +: OUT_W];
    tgl_next = tgl_reg ^ ((xw_ctl_next != xw_ctl_reg) || (xw_drive_next != xw_drive_reg));
    tms_cnt_next = tms ? tms_cnt_reg + ((tms_cnt_reg < tap_pkg::TMS_RESET_EDGES) ? 3'h1 : 3'h0) : 3'h0;
  end

  // Transfer word, toggle and mode-select run counter
  always_ff @(posedge tck or negedge rst_tck_n_reg) begin
    if (!rst_tck_n_reg) begin
      xw_ctl_reg <= '{extest: 1'h0, floating: 1'h0, drive_en: 1'h1};
      xw_drive_reg <= '0;
      tgl_reg <= 1'h0;
      tms_cnt_reg <= 3'h0;
    end else begin
      xw_ctl_reg <= xw_ctl_next;
      xw_drive_reg <= xw_drive_next;
      tgl_reg <= tgl_next;
      tms_cnt_reg <= tms_cnt_next;
    end
  end

  level_sync #(
    .W(1)
  ) u_tgl_sync (
    .clk(clk),
    .nrst(nrst),
    .en(ce),
    .d(tgl_reg),
    .q(tgl_s)
  );

  // ****************************************
  // Read data pins
  // ****************************************
  // Take the word on a toggle edge; pins follow core or scan
  always_comb begin
    tgl_seen_next = tgl_s;
    ctl_next = (tgl_s != tgl_seen_reg) ? xw_ctl_reg : ctl_reg;
    drive_next = (tgl_s != tgl_seen_reg) ? xw_drive_reg : drive_reg;
    pin_q_next = ctl_reg.extest ? drive_reg : core_q;
    pin_q_oe_next = ctl_reg.extest ? ctl_reg.drive_en : (core_q_oe && !ctl_reg.floating);
  end

  // System side state, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tgl_seen_reg <= 1'h0;
      ctl_reg <= '{extest: 1'h0, floating: 1'h0, drive_en: 1'h1};
      drive_reg <= '0;
      pin_q <= '0;
      pin_q_oe <= 1'h0;
    end else if (ce) begin
      tgl_seen_reg <= tgl_seen_next;
      ctl_reg <= ctl_next;
      drive_reg <= drive_next;
      pin_q <= pin_q_next;
      pin_q_oe <= pin_q_oe_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_five_high;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      tms_cnt_reg == tap_pkg::TMS_RESET_EDGES |-> state_reg == tap_pkg::TLR;
  endproperty
  a_five_high: assert property (p_five_high) else $error("Five mode-high edges did not reset");

  property p_reset_idcode;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::TLR |=> ir_reg == CODE_IDCODE;
  endproperty
  a_reset_idcode: assert property (p_reset_idcode) else $error("Reset state left wrong instruction");

  property p_ir_capture;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::CAP_IR |=> ir_sh_reg[1:0] == tap_pkg::IR_CAPTURE;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("Instruction capture pattern wrong");

  property p_ir_update;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      ir_reg != $past(ir_reg) |-> $past(state_reg) inside {tap_pkg::UPD_IR, tap_pkg::TLR};
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction changed outside update");

  // First shift edge shows the identity LSB, launched on the fall before it
  property p_id_capture;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::CAP_DR && ir_reg == CODE_IDCODE ##1 state_reg == tap_pkg::SH_DR
        |-> id_sh_reg == ID_VALUE && tdo_oe && tdo_out == ID_VALUE[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("Identity not captured or shifted");

  property p_bypass_clear;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::CAP_DR && sel == tap_pkg::SEL_BYPASS |=> !bypass_reg;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear) else $error("Bypass not cleared on capture");

  property p_tdo_drive;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      tdo_oe == (state_reg inside {tap_pkg::SH_IR, tap_pkg::SH_DR});
  endproperty
  a_tdo_drive: assert property (p_tdo_drive) else $error("Serial output driven outside shift");

  property p_bsr_shift;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::SH_DR && sel == tap_pkg::SEL_BSR
        |=> bsr_sh_reg[tap_pkg::BSR_LEN-1] == $past(tdi) && bsr_sh_reg[0] == $past(bsr_sh_reg[1]);
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("Boundary shift wrong");

  property p_bsr_capture;
    @(posedge tck) disable iff (!rst_tck_n_reg)
      state_reg == tap_pkg::CAP_DR && sel == tap_pkg::SEL_BSR |=> bsr_sh_reg == $past(ring);
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("Pin ring not captured");

  property p_float;
    @(posedge clk) disable iff (!nrst)
      ce && ctl_reg.floating && !ctl_reg.extest |=> !pin_q_oe;
  endproperty
  a_float: assert property (p_float) else $error("Read data driven while floating");

  property p_extest;
    @(posedge clk) disable iff (!nrst)
      ce && ctl_reg.extest |=> pin_q == $past(drive_reg) && pin_q_oe == $past(ctl_reg.drive_en);
  endproperty
  a_extest: assert property (p_extest) else $error("Preloaded cells not on pins");

endmodule

// ===== tb/tap_master.sv
// Board-side test controller model driving the test clock, mode and data.
// Assumes the caller waits for each task to return before starting another.

`timescale 1ns/1ns

module tap_master (
  // Test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  // ****************************************
  // Pin idle levels and clock steps
  // ****************************************
  // Clock parked low between frames, mode and data at pulled-up level
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One 48 ns test clock, output sampled before the rise
  task automatic step(input logic t, input logic d, output logic o, output logic e);
    tms = t;
    tdi = d;
    #24;
    o = tdo_out;
    e = tdo_oe;
    tck = 1'h1;
    #24;
    tck = 1'h0;
  endtask

  // Clocks with a fixed mode level, offset from the system clock
  task automatic idle(input int n, input logic t);
    logic o, e;
    #3;
    repeat (n) step(t, 1'h1, o, e);
  endtask

  // Five mode-high rises, then park in run-test-idle
  task automatic reset5;
    logic o, e;
    #3;
    repeat (5) step(1'h1, 1'h1, o, e);
    step(1'h0, 1'h1, o, e);
  endtask

  // Full scan from run-test-idle back to run-test-idle, LSB first
  task automatic scan(input logic ir, input int len, input logic [127:0] din,
                      output logic [127:0] dout, output int oecnt);
    logic o, e;
    dout = '0;
    oecnt = 0;
    #3;
    step(1'h1, 1'h1, o, e);
    if (ir) step(1'h1, 1'h1, o, e);
    step(1'h0, 1'h1, o, e);
    step(1'h0, 1'h1, o, e);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], o, e);
      dout[i] = o;
      oecnt += e;
    end
    step(1'h1, 1'h1, o, e);
    step(1'h0, 1'h1, o, e);
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the boundary-scan test port.
// Assumes default instruction codes and pin widths of the design.

`timescale 1ns/1ns

module testbench;
  logic clk, nrst, ce, tck, tms, tdi, tdo_out, tdo_oe, core_q_oe, pin_q_oe;
  logic [63:0] core_in;
  logic [35:0] core_q, pin_q;
  logic [2:0] cur;
  logic [108:0] pre;
  logic [127:0] dout, rnd;
  int fail_count, num_checks, seed, oecnt;

  // ****************************************
  // Design, partner and clock
  // ****************************************
  sram_boundary_scan_tap DUT (.clk(clk), .nrst(nrst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .core_in(core_in), .core_q(core_q), .core_q_oe(core_q_oe),
    .pin_q(pin_q), .pin_q_oe(pin_q_oe));
  tap_master m (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Checking and model
  // ****************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Expected pin enable and read data from instruction and preload
  function automatic logic [36:0] pins_exp;
    if (cur == tap_pkg::CODE_EXTEST_DEF) return {pre[108], pre[99:64]};
    return {(cur == tap_pkg::CODE_SAMPLEZ_DEF) ? 1'h0 : core_q_oe, core_q};
  endfunction

  task automatic settle;
    repeat (20) @(posedge clk);
    m.idle(3, 1'h0);
    check(128'({pin_q_oe, pin_q}), 128'(pins_exp()));
  endtask

  // Load one instruction, then capture and shift its data register
  task automatic run_code(input logic [2:0] code);
    logic [127:0] din, exp;
    logic [36:0] pe;
    int len;
    @(posedge clk);
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
    core_in <= rnd[63:0];
    core_q <= rnd[99:64];
    core_q_oe <= rnd[100];
    m.scan(1'h1, 3, 128'(code), dout, oecnt);
    check(dout, 128'({cur[2], tap_pkg::IR_CAPTURE}));
    check(128'(oecnt), 128'(3));
    check(128'(tdo_oe), 128'(0));
    cur = code;
    settle;
    din = {$random(seed), $random(seed), $random(seed), $random(seed)};
    exp = '0;
    if (code == tap_pkg::CODE_IDCODE_DEF) begin
      len = 32;
      exp[31:0] = tap_pkg::ID_VALUE_DEF;
    end else if (code == tap_pkg::CODE_BYPASS_DEF) begin
      len = 2;
      exp[1] = din[0];
    end else begin
      len = tap_pkg::BSR_LEN;
      pe = pins_exp();
      exp[108] = pe[36];
      exp[99:64] = pe[35:0];
      exp[63:0] = core_in;
    end
    m.scan(1'h0, len, din, dout, oecnt);
    check(dout, exp);
    check(128'(oecnt), 128'(len));
    if (code == tap_pkg::CODE_EXTEST_DEF || code == tap_pkg::CODE_SAMPLE_DEF) pre = din[108:0];
    settle;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    seed = 32'h1f177313;
    fail_count = 0;
    num_checks = 0;
    nrst = 1'h0;
    ce = 1'h1;
    core_in = '0;
    core_q = 36'h0a5a5a5a5;
    core_q_oe = 1'h1;
    cur = tap_pkg::CODE_IDCODE_DEF;
    pre = tap_pkg::BSR_RESET;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(128'(tdo_oe), 128'(0));
    check(128'({pin_q_oe, pin_q}), 128'(pins_exp()));
    m.idle(3, 1'h1);
    m.reset5;
    // Only defined codes are ever loaded
    run_code(tap_pkg::CODE_SAMPLE_DEF);
    run_code(tap_pkg::CODE_SAMPLEZ_DEF);
    run_code(tap_pkg::CODE_IDCODE_DEF);
    run_code(tap_pkg::CODE_BYPASS_DEF);
    run_code(tap_pkg::CODE_EXTEST_DEF);
    // Mode reset while outputs are driven from the preload cells
    m.reset5;
    cur = tap_pkg::CODE_IDCODE_DEF;
    pre = tap_pkg::BSR_RESET;
    settle;
    run_code(tap_pkg::CODE_EXTEST_DEF);
    close_out;
  end

  initial begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule
